// *** bench/test_byte_rotate_unit.sv ***
// self-checking bench for the byte rotate unit, driven cycle by cycle
module test_byte_rotate_unit;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i, rst_n_i, start_i, ext_set_en_i, carry_i;
    logic [15:0] instr_i; // instruction word
    logic [3:0] bank_select_reg_i;
    logic [11:0] index_base_i; // pointer for indexed offset mode
    logic [7:0] rd_data_i; // file read data held for the whole instruction
    logic [11:0] addr_o;
    logic [7:0] wr_data_o, w_data_o;
    logic rd_en_o, wr_en_o, w_we_o, flag_we_o, carry_we_o, carry_o;
    logic neg_o, zero_o, busy_o, illegal_o;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0; // watchdog against a hung handshake

    bru_top i_bru_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .start_i(start_i), .instr_i(instr_i), .ext_set_en_i(ext_set_en_i),
        .bank_select_reg_i(bank_select_reg_i), .index_base_i(index_base_i),
        .rd_data_i(rd_data_i), .carry_i(carry_i), .addr_o(addr_o),
        .rd_en_o(rd_en_o), .wr_en_o(wr_en_o), .wr_data_o(wr_data_o),
        .w_we_o(w_we_o), .w_data_o(w_data_o), .flag_we_o(flag_we_o),
        .carry_we_o(carry_we_o), .carry_o(carry_o), .neg_o(neg_o),
        .zero_o(zero_o), .busy_o(busy_o), .illegal_o(illegal_o));

    // free-running core clock, 10 ns period
    initial begin
        ref_clk_i = 0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // single comparison point; zero-extends narrow values
    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // the walk of one instruction is fixed, so every cycle is judged;
    // poke re-asserts start while busy, which must be ignored
    task automatic run(input logic [15:0] ins, input logic ext,
                       input logic [3:0] bank, input logic [11:0] base,
                       input logic [7:0] rd, input logic cin,
                       input logic [11:0] ea, input logic poke);
        logic [7:0] r;
        logic c, rrc;
        rrc = (ins[15:10] == bru_pkg::OP_RRC);
        r = rrc ? {cin, rd[7:1]} : {rd[6:0], rd[7]};
        c = rrc ? rd[0] : cin;
        @(posedge ref_clk_i);
        start_i <= 1'b1;
        instr_i <= ins;
        ext_set_en_i <= ext;
        bank_select_reg_i <= bank;
        index_base_i <= base;
        carry_i <= cin;
        rd_data_i <= rd;
        for (int k = 1; k <= 5; k++) begin
            @(posedge ref_clk_i);
            start_i <= (k == 2) && poke;
            #1;
            check("busy", busy_o, k < 5);
            check("rd_en", rd_en_o, k == 2);
            if (k == 2) check("addr", addr_o, ea);
            check("file_we", wr_en_o, k == 4 && ins[9]);
            check("w_we", w_we_o, k == 4 && !ins[9]);
            check("flag_we", flag_we_o, k == 4);
            check("carry_we", carry_we_o, k == 4 && rrc);
            if (k == 4) begin
                check("file_data", wr_data_o, r);
                check("w_data", w_data_o, r);
                check("carry", carry_o, c);
                check("neg", neg_o, r[7]);
                check("zero", zero_o, r == 8'h00);
            end
        end
    endtask

    // watchdog: the run needs under a hundred cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            final_report();
        end
    end

    // scenario: state one nanosecond after the release edge
    task automatic reset_state();
        #1;
        check("rst_zero", zero_o, 1'b1);
        check("rst_busy", busy_o, 1'b0);
        check("rst_addr", addr_o, 12'h000);
    endtask

    // scenario: both rotates on the access bank, values from the examples
    task automatic rotate_basic();
        run(16'h4620, 0, 4'h0, 12'h000, 8'hAB, 0, 12'h020, 1);
        run(16'h3080, 0, 4'h0, 12'h000, 8'hE6, 0, 12'hF80, 0);
    endtask

    // scenario: banked operands, zero result, carry kept on left rotate
    task automatic banked_operand();
        run(16'h3334, 0, 4'h5, 12'h000, 8'h01, 0, 12'h534, 1);
        run(16'h45FF, 0, 4'hA, 12'h000, 8'h80, 1, 12'hAFF, 0);
        run(16'h3110, 1, 4'h7, 12'h123, 8'h02, 1, 12'h710, 0);
    endtask

    // scenario: indexed offset at its limit, and just outside it
    task automatic indexed_offset();
        run(16'h465F, 1, 4'h3, 12'h123, 8'h00, 0, 12'h182, 0);
        run(16'h3060, 1, 4'h3, 12'h123, 8'hFF, 1, 12'hF60, 0);
        run(16'h445F, 0, 4'h3, 12'h123, 8'h55, 0, 12'h05F, 0);
    endtask

    // scenario: a neighbouring opcode is flagged and never started
    task automatic unknown_opcode();
        @(posedge ref_clk_i);
        start_i <= 1'b1;
        instr_i <= 16'h3420;
        #1;
        check("illegal", illegal_o, 1'b1);
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        #1;
        check("ill_busy", busy_o, 1'b0);
        check("ill_clear", illegal_o, 1'b0);
    endtask

    // scenario: reset in the read phase aborts; the next word runs clean
    task automatic reset_mid_run();
        @(posedge ref_clk_i);
        start_i <= 1'b1;
        instr_i <= 16'h4620;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        #1;
        check("mid_rd_en", rd_en_o, 1'b1);
        @(posedge ref_clk_i);
        #1;
        check("mid_busy", busy_o, 1'b0);
        check("mid_rd_off", rd_en_o, 1'b0);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("mid_zero", zero_o, 1'b1);
        run(16'h3080, 0, 4'h0, 12'h000, 8'hE6, 0, 12'hF80, 0);
    endtask

    initial begin
        start_i <= 1'b0;
        ext_set_en_i <= 1'b0;
        carry_i <= 1'b0;
        instr_i <= 16'h0000;
        bank_select_reg_i <= 4'h0;
        index_base_i <= 12'h000;
        rd_data_i <= 8'h00;
        rst_n_i <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        reset_state();
        rotate_basic();
        banked_operand();
        indexed_offset();
        unknown_opcode();
        reset_mid_run();
        final_report();
    end
endmodule

// *** hw/bru_pkg.sv ***
// constants for the byte rotate unit
package bru_pkg;
    // opcode top six bits of the 16-bit word
    localparam logic [5:0] OP_RLNC = 6'h11; // 0100 01
    localparam logic [5:0] OP_RRC = 6'h0C; // 0011 00
    localparam int OP_HI = 15;
    localparam int OP_LO = 10;
    localparam int D_BIT = 9;
    localparam int A_BIT = 8;
    localparam logic [7:0] IDX_LIMIT = 8'h5F; // highest indexed address
    localparam logic [7:0] ACC_HI_BASE = 8'h60; // access bank upper split
    localparam logic [3:0] ACC_BANK_LO = 4'h0;
    localparam logic [3:0] ACC_BANK_HI = 4'hF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    typedef enum logic [1:0] {
        BRU_Q1 = 2'b00, // decode
        BRU_Q2 = 2'b01, // read operand
        BRU_Q3 = 2'b10, // process
        BRU_Q4 = 2'b11  // write destination
    } bru_phase_t;
endpackage

// *** hw/bru_top.sv ***
// byte rotate datapath: rotate left no carry, rotate right through carry
// Notes on behaviour
// - left rotate: bit7 to bit0, carry kept
// - right rotate: carry in bit7, bit0 out
// - dest bit: 0 working reg, 1 file
// - access bit: 0 access bank, 1 bank select
// - extended, a clear, f<=95: indexed offset
// - one word, four phases: decode read process write
module bru_top (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // instruction side, all but rd_data_i taken on the accept edge
    input wire logic start_i,            // pulse: instruction word valid
    input wire logic [15:0] instr_i,     // instruction word
    input wire logic ext_set_en_i,       // extended instruction set on
    input wire logic [3:0] bank_select_reg_i,
    input wire logic [11:0] index_base_i, // indirect pointer for offset mode
    input wire logic [7:0] rd_data_i,    // file read data, same clock
    input wire logic carry_i,            // current carry flag
    // data memory side
    output logic [11:0] addr_o,          // data memory address
    output logic rd_en_o,                // read strobe in read phase
    output logic wr_en_o,                // file write strobe in write phase
    output logic [7:0] wr_data_o,        // result to file
    output logic w_we_o,                 // working register write strobe
    output logic [7:0] w_data_o,         // result to working register
    // status side
    output logic flag_we_o,              // flag update strobe
    output logic carry_we_o,             // carry update strobe
    output logic carry_o,
    output logic neg_o,
    output logic zero_o,
    // control
    output logic busy_o,                 // instruction in flight
    output logic illegal_o               // pulse: opcode not handled
);
    // sequencer state
    bru_pkg::bru_phase_t phase_q; // current quarter of the cycle
    logic active_q; // an instruction is in flight
    // fields captured when an instruction is taken
    logic is_rrc_q, dest_q; // right rotate selected, result to file
    logic [11:0] addr_q; // operand address held for the whole cycle
    logic cy_in_q; // carry as it stood when the word was taken
    // datapath registers
    logic [7:0] opnd_q, res_q; // operand read in, rotated result out
    logic cy_q; // carry reported at the write phase
    // decode of the incoming word, valid only with start_i
    logic [5:0] opc; // top six opcode bits
    logic dbit, abit; // destination and access select bits
    logic [7:0] fadr; // 8-bit file address field
    logic [11:0] addr_d; // address formed from the fields
    logic known; // opcode is one of the two rotates

    // field decode; meaningful only while start_i is high
    assign opc = instr_i[bru_pkg::OP_HI:bru_pkg::OP_LO];
    assign dbit = instr_i[bru_pkg::D_BIT];
    assign abit = instr_i[bru_pkg::A_BIT];
    assign fadr = instr_i[7:0];
    assign known = (opc == bru_pkg::OP_RLNC) || (opc == bru_pkg::OP_RRC);

    // address formation at decode; the bank select value is taken with
    // the word, so a later change to it cannot move a running access
    always_comb begin
        if (abit) begin
            // banked: upper nibble from the bank select register
            addr_d = {bank_select_reg_i, fadr};
        end else if (ext_set_en_i && fadr <= bru_pkg::IDX_LIMIT) begin
            // indexed offset: pointer plus literal, wraps at 12 bits
            addr_d = index_base_i + {4'h0, fadr};
        end else if (fadr < bru_pkg::ACC_HI_BASE) begin
            // access bank, lower part: general purpose bank 0
            addr_d = {bru_pkg::ACC_BANK_LO, fadr};
        end else begin
            // access bank, upper part: top bank
            addr_d = {bru_pkg::ACC_BANK_HI, fadr};
        end
    end

    // banked operand lands on the address port one cycle after the take
    bank_addr_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!active_q && start_i && known && abit) |=>
        addr_o == {$past(bank_select_reg_i), $past(fadr)})
        else $error("banked address wrong");

    // indexed offset wins over the access bank for low addresses
    index_mode_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!active_q && start_i && known && !abit && ext_set_en_i
         && fadr <= bru_pkg::IDX_LIMIT) |=>
        addr_o == $past(index_base_i) + {4'h0, $past(fadr)})
        else $error("indexed address wrong");

    // phase sequencer: one instruction cycle, four phases; the take edge
    // only arms active_q, so decode is the first cycle with busy_o high
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            phase_q <= bru_pkg::BRU_Q1;
            active_q <= 1'b0;
        end else begin
            case (phase_q)
                // decode: leave at once when armed, otherwise wait for a word
                bru_pkg::BRU_Q1: begin
                    if (active_q) phase_q <= bru_pkg::BRU_Q2;
                    else if (start_i && known) active_q <= 1'b1;
                end
                // read, then process: fixed one cycle each
                bru_pkg::BRU_Q2: phase_q <= bru_pkg::BRU_Q3;
                bru_pkg::BRU_Q3: phase_q <= bru_pkg::BRU_Q4;
                // write: drop busy so the next word can be taken next cycle
                bru_pkg::BRU_Q4: begin
                    phase_q <= bru_pkg::BRU_Q1;
                    active_q <= 1'b0;
                end
                default: phase_q <= bru_pkg::BRU_Q1; // all codes are used
            endcase
        end
    end

    // take, decode, read, process, write, then idle again
    four_phase_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!active_q && start_i && known) |=> ##1 rd_en_o ##2 flag_we_o
        ##1 !busy_o)
        else $error("phase sequence wrong");

    // latch the decoded fields; starts ignored while busy, so a word that
    // arrives mid-cycle is dropped rather than queued (no buffering here)
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            is_rrc_q <= 1'b0;
            dest_q <= 1'b0;
            addr_q <= 12'h000;
            cy_in_q <= 1'b0;
        end else if (!active_q && start_i && known) begin
            // capture all the cycle needs but the operand; later changes to these inputs are ignored
            is_rrc_q <= (opc == bru_pkg::OP_RRC);
            dest_q <= dbit;
            addr_q <= addr_d;
            cy_in_q <= carry_i;
        end
    end

    // read and process phases; opnd_q and res_q then hold until the next
    // instruction, which is what keeps the data outputs steady
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            opnd_q <= bru_pkg::BYTE_ZERO;
            res_q <= bru_pkg::BYTE_ZERO;
            cy_q <= 1'b0;
        end else if (phase_q == bru_pkg::BRU_Q2) begin
            // read: the file answers on the same clock as rd_en_o
            opnd_q <= rd_data_i;
        end else if (phase_q == bru_pkg::BRU_Q3) begin
            if (is_rrc_q) begin
                // right through carry: old carry enters at the top
                res_q <= {cy_in_q, opnd_q[7:1]};
                cy_q <= opnd_q[0];
            end else begin
                // left without carry: top bit wraps to the bottom
                res_q <= {opnd_q[6:0], opnd_q[7]};
                cy_q <= cy_in_q;
            end
        end
    end

    // left rotate result, one cycle after the process phase
    rlnc_result_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (phase_q == bru_pkg::BRU_Q3 && active_q && !is_rrc_q) |=>
        res_q == {$past(opnd_q[6:0]), $past(opnd_q[7])})
        else $error("left rotate result wrong");

    // right rotate result and the carry it shifts out
    rrc_result_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (phase_q == bru_pkg::BRU_Q3 && active_q && is_rrc_q) |=>
        res_q == {cy_in_q, $past(opnd_q[7:1])} && cy_q == $past(opnd_q[0]))
        else $error("right rotate result wrong");

    // write phase strobes; data held from flops
    logic wr_ph; // the write quarter of a live instruction
    assign wr_ph = active_q && phase_q == bru_pkg::BRU_Q4;
    assign busy_o = active_q;
    assign addr_o = addr_q;
    assign rd_en_o = active_q && phase_q == bru_pkg::BRU_Q2;
    assign wr_en_o = wr_ph && dest_q;
    assign w_we_o = wr_ph && !dest_q;
    // both data ports carry the same register; only the strobes differ
    assign wr_data_o = res_q;
    assign w_data_o = res_q;
    assign flag_we_o = wr_ph;
    // left rotate never writes carry, so it raises no carry strobe
    assign carry_we_o = wr_ph && is_rrc_q;
    assign carry_o = cy_q;
    assign neg_o = res_q[7];
    assign zero_o = (res_q == bru_pkg::BYTE_ZERO);
    // an unknown opcode is reported but never started
    assign illegal_o = !active_q && start_i && !known;

    // left rotate leaves carry alone and reports the old value
    rlnc_carry_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_ph && !is_rrc_q) |-> !carry_we_o && carry_o == cy_in_q)
        else $error("left rotate touched carry");

    // exactly one destination strobe, chosen by the d bit
    dest_sel_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_ph |-> (wr_en_o == dest_q) && (w_we_o != dest_q))
        else $error("destination steering wrong");

    // flags judged from the operand, not from the result register
    flags_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        flag_we_o |-> zero_o == (is_rrc_q
            ? (opnd_q[7:1] == '0 && !cy_in_q) : opnd_q == bru_pkg::BYTE_ZERO)
        && neg_o == (is_rrc_q ? cy_in_q : opnd_q[6]))
        else $error("flags wrong");

    // main scenarios: each rotate, file destination, zero, indexed mode
    c_rlnc: cover property (@(posedge ref_clk_i) wr_ph && !is_rrc_q);
    c_rrc_f: cover property (@(posedge ref_clk_i) wr_ph && is_rrc_q && dest_q);
    c_zero: cover property (@(posedge ref_clk_i) flag_we_o && zero_o);
    c_index: cover property (@(posedge ref_clk_i)
        !active_q && start_i && known && !abit && ext_set_en_i
        && fadr <= bru_pkg::IDX_LIMIT);
endmodule
